// file: src/sdadc_pkg.sv
// Purpose: Constants, types and shared helpers of the converter control register bank.
// Assumes: One 8-bit register per address; addresses 0x00 to 0x11.
// Notes:   Used by sdadc_ctrl only through scoped names.
//
// Function
// - Software register traffic passes over the internal two-wire serial bus; the result strobe also loads the result bytes and end of conversion.
// - Each 24-bit result is kept as low, middle and high bytes at consecutive addresses.
// - Reset loads the table values: control A is 0x20 (powered down), test is 0xE4.
// - The 12-bit reference DAC code is the high register above the low register nibble.
// - Writes to the low DAC register fill a shadow, copied to the live register on a high write.
// - The upper four bits of the low DAC register read as zero.
// - DAC control bit 7 switches the reference DAC on when one and off when zero.
// - DAC control bit 6 picks the DAC reference (0 analog supply, 1 common mode); bits 5-0 read 0.
// - Bandgap is off only with power-down set and common reference off; common ref follows its bit.
// - Power bit 7 enables the common-mode reference; when zero its output floats.
// - The reference gain bits pass the external reference whole, halved or quartered.
// - Power-down set forces the module off whatever the sleep and filter reset bits say.
////////////////////////////////////////////////////////////////////////////////////////////////////
package sdadc_pkg;

    localparam int         NUM_REGS        = 18;

    // Register addresses
    localparam logic [7:0] ADR_POWER       = 8'h00;
    localparam logic [7:0] ADR_AMP_GAIN    = 8'h01;
    localparam logic [7:0] ADR_AMP_INPUT   = 8'h02;
    localparam logic [7:0] ADR_AMP_CHAN    = 8'h03;
    localparam logic [7:0] ADR_RES_LOW     = 8'h04;
    localparam logic [7:0] ADR_RES_MID     = 8'h05;
    localparam logic [7:0] ADR_RES_HIGH    = 8'h06;
    localparam logic [7:0] ADR_CTRL_A      = 8'h07;
    localparam logic [7:0] ADR_CTRL_B      = 8'h08;
    localparam logic [7:0] ADR_CLK_SEL     = 8'h09;
    localparam logic [7:0] ADR_TEST        = 8'h0A;
    localparam logic [7:0] ADR_DAC_HIGH    = 8'h0B;
    localparam logic [7:0] ADR_DAC_LOW     = 8'h0C;
    localparam logic [7:0] ADR_DAC_CTRL    = 8'h0D;
    localparam logic [7:0] ADR_SER_CTRL    = 8'h0E;
    localparam logic [7:0] ADR_SER_TMO     = 8'h10;
    localparam logic [7:0] ADR_OSC         = 8'h11;

    // Reset values
    localparam logic [7:0] RST_DEFAULT     = 8'h00;
    localparam logic [7:0] RST_CTRL_A      = 8'h20;
    localparam logic [7:0] RST_TEST        = 8'hE4;
    localparam logic [7:0] RST_OSC         = 8'h01;

    // Field positions
    localparam int         BIT_COMMON_REF  = 7;
    localparam int         BIT_FILT_RESET  = 7;
    localparam int         BIT_SLEEP       = 6;
    localparam int         BIT_POWER_DOWN  = 5;
    localparam int         BIT_EOC         = 1;
    localparam int         BIT_DAC_ON      = 7;
    localparam int         BIT_DAC_SRC     = 6;
    localparam int         POS_REF_GAIN    = 5;
    localparam int         POS_FILT_MODE   = 5;

    // Serial state machine, one-hot
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_ADDR    = 9'h002,
        ST_ACK_ADR = 9'h004,
        ST_PTR     = 9'h008,
        ST_ACK_WR  = 9'h010,
        ST_WDATA   = 9'h020,
        ST_RDATA   = 9'h040,
        ST_ACK_RD  = 9'h080,
        ST_RD_NEXT = 9'h100
    } sdadc_st_e;

    // Bits that exist and read back
    function automatic logic [7:0] rd_mask(input logic [7:0] a);
        case (a)
            ADR_AMP_GAIN:  rd_mask = 8'h7F;
            ADR_AMP_INPUT: rd_mask = 8'h7E;
            ADR_AMP_CHAN:  rd_mask = 8'h3F;
            ADR_CTRL_B:    rd_mask = 8'hFE;
            ADR_CLK_SEL:   rd_mask = 8'h1F;
            ADR_DAC_LOW:   rd_mask = 8'h0F;
            ADR_DAC_CTRL:  rd_mask = 8'hC0;
            ADR_SER_CTRL:  rd_mask = 8'h8C;
            ADR_OSC:       rd_mask = 8'h07;
            8'h0F:         rd_mask = 8'h00;
            default:       rd_mask = (a < 8'h12) ? 8'hFF : 8'h00;
        endcase
    endfunction : rd_mask

    // Bits that software may change
    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        case (a)
            ADR_RES_LOW, ADR_RES_MID, ADR_RES_HIGH: wr_mask = 8'h00;
            ADR_CTRL_B:    wr_mask = 8'hFC;
            ADR_OSC:       wr_mask = 8'h05;
            default:       wr_mask = rd_mask(a);
        endcase
    endfunction : wr_mask

endpackage : sdadc_pkg

// file: src/sdadc_ctrl.sv
// Purpose: Control and data register bank of the 24-bit converter, reached as a serial slave.
// Assumes: SCL and SDA arrive from outside the clock domain; result strobe is on CLK_I.
// Notes:   SDA is open drain: SDA_O stays low and SDA_OE_N_O low means the line is pulled.
////////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module sdadc_ctrl #(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    input  wire logic [23:0] RESULT_I,
    input  wire logic        RESULT_VALID_I,
    output logic             COMMON_REF_ON_O,
    output logic             BANDGAP_ON_O,
    output logic             CONVERTER_POWER_DOWN_O,
    output logic             CONVERTER_SLEEP_SELECT_O,
    output logic             FILTER_RESET_O,
    output logic [2:0]       FILTER_MODE_SELECT_O,
    output logic [6:0]       PERF_TUNING_BITS_O,
    output logic [1:0]       REF_GAIN_SELECT_BITS_O,
    output logic             REFDAC_ON_O,
    output logic             REFDAC_SOURCE_SELECT_O,
    output logic [11:0]      REFDAC_CODE_O
);

    typedef struct packed {
        logic [sdadc_pkg::NUM_REGS-1:0][7:0] regs;
        logic [3:0]           dal_shadow;
        logic [7:0]           ptr;
        logic [7:0]           sh;
        logic [2:0]           cnt;
        logic                 rw;
        logic                 ack_on;
        sdadc_pkg::sdadc_st_e st;
        logic                 scl_m;
        logic                 scl_s;
        logic                 scl_d;
        logic                 sda_m;
        logic                 sda_s;
        logic                 sda_d;
        logic                 sda_oe_n;
        logic                 bandgap_on;
        logic                 sleep_on;
        logic                 frst_on;
    } sdadc_state_s;

    sdadc_state_s s;
    sdadc_state_s n;
    logic [1:0]   rst_q;
    logic         rst_n;
    logic         wr_en;
    logic [7:0]   wr_adr;
    logic [7:0]   wr_dat;
    logic         scl_rise;
    logic         scl_fall;
    logic         bus_start;
    logic         bus_stop;

    // Reads a register with absent bits forced to zero
    function automatic logic [7:0] read_reg(input logic [7:0] a, input sdadc_state_s st);
        if (a < 8'h12)
            read_reg = st.regs[a[4:0]] & sdadc_pkg::rd_mask(a);
        else
            read_reg = 8'h00;
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // Bus events seen on the synchronised copies only
    assign scl_rise  = s.scl_s & ~s.scl_d;
    assign scl_fall  = ~s.scl_s & s.scl_d;
    assign bus_start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
    assign bus_stop  = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: serial slave, register writes, result capture
    always_comb begin
        n      = s;
        wr_en  = 1'b0;
        wr_adr = s.ptr;
        wr_dat = {s.sh[6:0], s.sda_s};
        n.scl_m = SCL_I;
        n.scl_s = s.scl_m;
        n.scl_d = s.scl_s;
        n.sda_m = SDA_I;
        n.sda_s = s.sda_m;
        n.sda_d = s.sda_s;
        if (bus_start) begin
            n.st       = sdadc_pkg::ST_ADDR;
            n.cnt      = 3'h0;
            n.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            n.st       = sdadc_pkg::ST_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            case (s.st)
                sdadc_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        n.sh  = {s.sh[6:0], s.sda_s};
                        n.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            n.rw     = s.sda_s;
                            n.ack_on = 1'b0;
                            n.st     = (s.sh[6:0] == DEV_ADDR) ? sdadc_pkg::ST_ACK_ADR
                                                               : sdadc_pkg::ST_IDLE;
                        end
                    end
                end
                sdadc_pkg::ST_ACK_ADR: begin
                    if (scl_fall) begin
                        if (!s.ack_on) begin
                            n.ack_on   = 1'b1;
                            n.sda_oe_n = 1'b0;
                        end else begin
                            n.ack_on = 1'b0;
                            n.cnt    = 3'h0;
                            if (s.rw) begin
                                n.st       = sdadc_pkg::ST_RDATA;
                                n.sh       = read_reg(s.ptr, s);
                                n.sda_oe_n = n.sh[7];
                            end else begin
                                n.st       = sdadc_pkg::ST_PTR;
                                n.sda_oe_n = 1'b1;
                            end
                        end
                    end
                end
                sdadc_pkg::ST_PTR, sdadc_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        n.sh  = {s.sh[6:0], s.sda_s};
                        n.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            n.ack_on = 1'b0;
                            n.st     = sdadc_pkg::ST_ACK_WR;
                            if (s.st == sdadc_pkg::ST_PTR) begin
                                n.ptr = wr_dat;
                            end else begin
                                wr_en = 1'b1;
                                n.ptr = s.ptr + 8'h01;
                            end
                        end
                    end
                end
                sdadc_pkg::ST_ACK_WR: begin
                    if (scl_fall) begin
                        if (!s.ack_on) begin
                            n.ack_on   = 1'b1;
                            n.sda_oe_n = 1'b0;
                        end else begin
                            n.ack_on   = 1'b0;
                            n.cnt      = 3'h0;
                            n.st       = sdadc_pkg::ST_WDATA;
                            n.sda_oe_n = 1'b1;
                        end
                    end
                end
                sdadc_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (s.cnt == 3'h7) begin
                            n.sda_oe_n = 1'b1;
                            n.st       = sdadc_pkg::ST_ACK_RD;
                        end else begin
                            n.sh       = {s.sh[6:0], 1'b0};
                            n.sda_oe_n = s.sh[6];
                            n.cnt      = s.cnt + 3'h1;
                        end
                    end
                end
                sdadc_pkg::ST_ACK_RD: begin
                    if (scl_rise) begin
                        n.ptr = s.ptr + 8'h01;
                        n.st  = s.sda_s ? sdadc_pkg::ST_IDLE : sdadc_pkg::ST_RD_NEXT;
                    end
                end
                sdadc_pkg::ST_RD_NEXT: begin
                    if (scl_fall) begin
                        n.cnt      = 3'h0;
                        n.st       = sdadc_pkg::ST_RDATA;
                        n.sh       = read_reg(s.ptr, s);
                        n.sda_oe_n = n.sh[7];
                    end
                end
                sdadc_pkg::ST_IDLE: begin
                    n.sda_oe_n = 1'b1;
                end
                default: begin
                    n.st       = sdadc_pkg::ST_IDLE;
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end
        // Register write with masking and shadowed DAC low nibble
        if (wr_en) begin
            if (wr_adr == sdadc_pkg::ADR_DAC_LOW) begin
                n.dal_shadow = wr_dat[3:0];
            end else if (wr_adr < 8'h12) begin
                n.regs[wr_adr[4:0]] = (s.regs[wr_adr[4:0]] & ~sdadc_pkg::wr_mask(wr_adr))
                                    | (wr_dat & sdadc_pkg::wr_mask(wr_adr));
            end
            if (wr_adr == sdadc_pkg::ADR_DAC_HIGH)
                n.regs[sdadc_pkg::ADR_DAC_LOW[4:0]] = {4'h0, s.dal_shadow};
            if (wr_adr == sdadc_pkg::ADR_CTRL_B && !wr_dat[sdadc_pkg::BIT_EOC])
                n.regs[sdadc_pkg::ADR_CTRL_B[4:0]][sdadc_pkg::BIT_EOC] = 1'b0;
        end
        // Result capture sets end of conversion; set wins over a clear
        if (RESULT_VALID_I) begin
            n.regs[sdadc_pkg::ADR_RES_LOW[4:0]]  = RESULT_I[7:0];
            n.regs[sdadc_pkg::ADR_RES_MID[4:0]]  = RESULT_I[15:8];
            n.regs[sdadc_pkg::ADR_RES_HIGH[4:0]] = RESULT_I[23:16];
            n.regs[sdadc_pkg::ADR_CTRL_B[4:0]][sdadc_pkg::BIT_EOC] = 1'b1;
        end
        // Power decode from the next register values
        n.bandgap_on = ~(n.regs[sdadc_pkg::ADR_CTRL_A[4:0]][sdadc_pkg::BIT_POWER_DOWN]
                       & ~n.regs[sdadc_pkg::ADR_POWER[4:0]][sdadc_pkg::BIT_COMMON_REF]);
        n.sleep_on   = n.regs[sdadc_pkg::ADR_CTRL_A[4:0]][sdadc_pkg::BIT_SLEEP]
                     & ~n.regs[sdadc_pkg::ADR_CTRL_A[4:0]][sdadc_pkg::BIT_POWER_DOWN];
        n.frst_on    = n.regs[sdadc_pkg::ADR_CTRL_A[4:0]][sdadc_pkg::BIT_FILT_RESET]
                     & ~n.regs[sdadc_pkg::ADR_CTRL_A[4:0]][sdadc_pkg::BIT_POWER_DOWN];
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State register with table reset values
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            for (int i = 0; i < sdadc_pkg::NUM_REGS; i++) begin
                s.regs[i] <= sdadc_pkg::RST_DEFAULT;
            end
            s.regs[sdadc_pkg::ADR_CTRL_A[4:0]] <= sdadc_pkg::RST_CTRL_A;
            s.regs[sdadc_pkg::ADR_TEST[4:0]]   <= sdadc_pkg::RST_TEST;
            s.regs[sdadc_pkg::ADR_OSC[4:0]]    <= sdadc_pkg::RST_OSC;
            s.st       <= sdadc_pkg::ST_IDLE;
            s.scl_m    <= 1'b1;
            s.scl_s    <= 1'b1;
            s.scl_d    <= 1'b1;
            s.sda_m    <= 1'b1;
            s.sda_s    <= 1'b1;
            s.sda_d    <= 1'b1;
            s.sda_oe_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs taken straight from state flip-flops; SDA_O is tied low
    assign SDA_O                    = 1'b0;
    assign SDA_OE_N_O               = s.sda_oe_n;
    assign COMMON_REF_ON_O          = s.regs[sdadc_pkg::ADR_POWER[4:0]]
                                            [sdadc_pkg::BIT_COMMON_REF];
    assign PERF_TUNING_BITS_O       = s.regs[sdadc_pkg::ADR_POWER[4:0]][6:0];
    assign BANDGAP_ON_O             = s.bandgap_on;
    assign CONVERTER_POWER_DOWN_O   = s.regs[sdadc_pkg::ADR_CTRL_A[4:0]]
                                            [sdadc_pkg::BIT_POWER_DOWN];
    assign CONVERTER_SLEEP_SELECT_O = s.sleep_on;
    assign FILTER_RESET_O           = s.frst_on;
    assign FILTER_MODE_SELECT_O     = s.regs[sdadc_pkg::ADR_CTRL_B[4:0]]
                                            [sdadc_pkg::POS_FILT_MODE+:3];
    assign REF_GAIN_SELECT_BITS_O   = s.regs[sdadc_pkg::ADR_AMP_GAIN[4:0]]
                                            [sdadc_pkg::POS_REF_GAIN+:2];
    assign REFDAC_ON_O              = s.regs[sdadc_pkg::ADR_DAC_CTRL[4:0]]
                                            [sdadc_pkg::BIT_DAC_ON];
    assign REFDAC_SOURCE_SELECT_O   = s.regs[sdadc_pkg::ADR_DAC_CTRL[4:0]]
                                            [sdadc_pkg::BIT_DAC_SRC];
    assign REFDAC_CODE_O            = {s.regs[sdadc_pkg::ADR_DAC_HIGH[4:0]],
                                       s.regs[sdadc_pkg::ADR_DAC_LOW[4:0]][3:0]};

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_result_capture: assert property (@(posedge CLK_I) disable iff (!rst_n)
        RESULT_VALID_I |=> {s.regs[6], s.regs[5], s.regs[4]} == $past(RESULT_I))
        else $error("result bytes not captured");
    a_reset_values: assert property (@(posedge CLK_I) disable iff (!rst_n)
        $rose(rst_n) |-> (s.regs[7] == sdadc_pkg::RST_CTRL_A && s.regs[10] == sdadc_pkg::RST_TEST))
        else $error("reset values wrong");
    a_dal_shadow_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
        (wr_en && wr_adr == 8'h0C) |=> $stable(REFDAC_CODE_O) && s.dal_shadow == $past(wr_dat[3:0]))
        else $error("low DAC write reached live code");
    a_dal_shadow_copy: assert property (@(posedge CLK_I) disable iff (!rst_n)
        (wr_en && wr_adr == 8'h0B) |=> REFDAC_CODE_O == {$past(wr_dat), $past(s.dal_shadow)})
        else $error("high DAC write did not copy shadow");
    a_dal_upper_zero: assert property (@(posedge CLK_I) disable iff (!rst_n)
        (read_reg(8'h0C, s) & 8'hF0) == 8'h00 && (read_reg(8'h0D, s) & 8'h3F) == 8'h00)
        else $error("DAC absent bits read nonzero");
    a_dac_enable: assert property (@(posedge CLK_I) disable iff (!rst_n)
        (wr_en && wr_adr == 8'h0D) |=> REFDAC_ON_O == $past(wr_dat[7])
                                      && REFDAC_SOURCE_SELECT_O == $past(wr_dat[6]))
        else $error("DAC control not applied");
    a_bandgap_table: assert property (@(posedge CLK_I) disable iff (!rst_n)
        BANDGAP_ON_O == !(CONVERTER_POWER_DOWN_O && !COMMON_REF_ON_O))
        else $error("bandgap does not follow power table");
    a_common_ref: assert property (@(posedge CLK_I) disable iff (!rst_n)
        (wr_en && wr_adr == 8'h00) |=> COMMON_REF_ON_O == $past(wr_dat[7]))
        else $error("common reference enable not applied");
    a_power_down_wins: assert property (@(posedge CLK_I) disable iff (!rst_n)
        CONVERTER_POWER_DOWN_O |-> !CONVERTER_SLEEP_SELECT_O && !FILTER_RESET_O)
        else $error("sleep or filter reset active while powered down");
    a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!rst_n)
        read_reg(8'h0F, s) == 8'h00 && (read_reg(8'h01, s) & 8'h80) == 8'h00)
        else $error("unimplemented bits read nonzero");
    a_sda_drive_only: assert property (@(posedge CLK_I) disable iff (!rst_n)
        !SDA_OE_N_O |-> (s.st inside {sdadc_pkg::ST_ACK_ADR, sdadc_pkg::ST_ACK_WR,
                                      sdadc_pkg::ST_RDATA}))
        else $error("SDA pulled outside acknowledge or read data");

endmodule : sdadc_ctrl

// file: bench/sdadc_host_model.sv
// Purpose: Host core model that reaches the register bank over the two-wire bus.
// Assumes: Each SCL phase lasts at least six CLK_I cycles; SDA is open drain with a pull-up.
// Notes:   Lines change only at CLK_I falling edges.
`timescale 1ns/1ns
module sdadc_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    ////////////////////////////////////////
    // One bus phase
    task automatic half();
        repeat (6) @(negedge clk_i);
    endtask : half
    // Start or repeated start, ends with SCL low
    task automatic start();
        sda_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b0;
        half();
        scl_o = 1'b0;
        half();
    endtask : start
    // Stop, leaves the bus released
    task automatic stop();
        sda_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_o = 1'b1;
        half();
    endtask : stop
    // One bit: data set while SCL is low, line sampled at the end of the high phase
    task automatic bitx(input logic b, output logic s);
        sda_o = b;
        half();
        scl_o = 1'b1;
        half();
        s = sda_i;
        scl_o = 1'b0;
        half();
    endtask : bitx
    // Byte MSB first plus acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(ai, ao);
    endtask : xfer
    // Register write; nak is high if any byte went unacknowledged
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] p, d, output logic nak);
        logic [7:0] q;
        logic [2:0] n;
        start();
        xfer({a, 1'b0}, 1'b1, q, n[0]);
        xfer(p, 1'b1, q, n[1]);
        xfer(d, 1'b1, q, n[2]);
        stop();
        nak = |n;
    endtask : wr_reg
    // Register read through a repeated start, last byte not acknowledged
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] q);
        logic n;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q, n);
        xfer(p, 1'b1, q, n);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q, n);
        xfer(8'hFF, 1'b1, q, n);
        stop();
    endtask : rd_reg
    // Two-byte read: first byte acknowledged so a second byte follows, second not
    task automatic rd_pair(input logic [7:0] p, output logic [15:0] q);
        logic       n;
        logic [7:0] t;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, t, n);
        xfer(p, 1'b1, t, n);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, t, n);
        xfer(8'hFF, 1'b0, q[7:0], n);
        xfer(8'hFF, 1'b1, q[15:8], n);
        stop();
    endtask : rd_pair
endmodule : sdadc_host_model

// file: bench/sdadc_ctrl_tb.sv
// Purpose: Self-checking bench of the converter control register bank.
// Assumes: Host model drives the two-wire bus; the bench drives the result strobe.
// Notes:   An integer reference model mirrors all registers and control outputs.
`timescale 1ns/1ns
module sdadc_ctrl_tb;
    localparam logic [6:0] ADDR = 7'h2A;  // Arbitrary value
    logic        clk = 1'b0;
    logic        nrst = 1'b1;
    logic        scl, hsda, sda_o, sda_oe_n, sda;
    logic [23:0] result = 24'h000000;
    logic        result_valid = 1'b0;
    logic [30:0] outs;
    logic [7:0]  regs [0:18];
    logic [7:0]  wm [0:18] = '{8'hFF, 8'h7F, 8'h7E, 8'h3F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFC,
                               8'h1F, 8'hFF, 8'hFF, 8'h0F, 8'hC0, 8'h8C, 8'h00, 8'hFF, 8'h05, 8'h00};
    logic [7:0]  shadow = 8'h00;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    // Open-drain wire with pull-up
    assign sda = hsda & (sda_oe_n | sda_o);
    always #4 clk = ~clk;
    sdadc_host_model #(.DEV_ADDR(ADDR)) u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
    sdadc_ctrl #(.DEV_ADDR(ADDR)) i_sdadc_ctrl (
        .CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .RESULT_I(result), .RESULT_VALID_I(result_valid), .COMMON_REF_ON_O(outs[30]),
        .BANDGAP_ON_O(outs[29]), .CONVERTER_POWER_DOWN_O(outs[28]),
        .CONVERTER_SLEEP_SELECT_O(outs[27]), .FILTER_RESET_O(outs[26]),
        .FILTER_MODE_SELECT_O(outs[25:23]), .PERF_TUNING_BITS_O(outs[22:16]),
        .REF_GAIN_SELECT_BITS_O(outs[15:14]), .REFDAC_ON_O(outs[13]),
        .REFDAC_SOURCE_SELECT_O(outs[12]), .REFDAC_CODE_O(outs[11:0]));
    ////////////////////////////////////////
    // Expected control outputs from the modelled registers
    function automatic logic [30:0] exp_outs();
        logic [7:0] p, c;
        p = regs[0];
        c = regs[7];
        exp_outs = {p[7], ~(c[5] & ~p[7]), c[5], c[6] & ~c[5], c[7] & ~c[5], regs[8][7:5],
                    p[6:0], regs[1][6:5], regs[13][7:6], regs[11], regs[12][3:0]};
    endfunction : exp_outs
    // Compare and count
    task automatic chk(input string what, input logic [30:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Write through the host, update the model, check the outputs
    task automatic wr(input logic [7:0] a, d);
        logic nak;
        u_host.wr_reg(ADDR, a, d, nak);
        if (a == 8'h0C) begin
            shadow = d & 8'h0F;
        end else if (a == 8'h0B) begin
            regs[11] = d;
            regs[12] = shadow;
        end else if (a == 8'h08) begin
            regs[8] = (d & 8'hFC) | (regs[8] & d & 8'h02);
        end else begin
            regs[a] = (regs[a] & ~wm[a]) | (d & wm[a]);
        end
        chk("ack", 31'h0, {30'h0, nak});
        chk("outputs", exp_outs(), outs);
    endtask : wr
    // Read through the host and compare
    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] q;
        u_host.rd_reg(a, q);
        chk("register", {23'h0, regs[a]}, {23'h0, q});
    endtask : rd_chk
    // Verdict and end of run
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        logic [31:0] res;
        logic        nak;
        logic [7:0]  a8, d8;
        logic [15:0] pair;
        // Reset edge before the first clock so the design never runs unreset
        #1 nrst = 1'b0;
        void'($urandom(95139));
        for (int i = 0; i < 19; i++) begin
            regs[i] = 8'h00;
        end
        regs[7] = 8'h20;
        regs[10] = 8'hE4;
        regs[17] = 8'h01;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        chk("outputs", exp_outs(), outs);
        for (int a = 0; a < 19; a++) begin
            rd_chk(a[7:0]);
        end
        wr(8'h0C, 8'hA5);
        rd_chk(8'h0C);
        wr(8'h0B, 8'hC3);
        rd_chk(8'h0C);
        wr(8'h0D, 8'hFF);
        rd_chk(8'h0D);
        // Power table, gain codes and tuning per filter mode
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, k[0] ? 8'h40 : 8'h00);
            wr(8'h00, {k[1], k[0] ? 7'h3C : 7'h28});
            wr(8'h07, {2'b11, k[0], 5'h00});
            wr(8'h01, {1'b0, k[1:0], 5'h15});
        end
        // Conversion result capture
        res = $urandom();
        result = res[23:0];
        result_valid = 1'b1;
        @(negedge clk);
        result_valid = 1'b0;
        {regs[6], regs[5], regs[4]} = res[23:0];
        regs[8][1] = 1'b1;
        for (int a = 4; a < 9; a++) begin
            rd_chk(a[7:0]);
        end
        // Burst read walks the pointer from the middle to the high result byte
        u_host.rd_pair(8'h05, pair);
        chk("pair", {15'h0, regs[6], regs[5]}, {15'h0, pair});
        // Foreign address is not acknowledged and changes nothing
        u_host.wr_reg(ADDR ^ 7'h01, 8'h00, 8'h55, nak);
        chk("nack", 31'h1, {30'h0, nak});
        rd_chk(8'h00);
        for (int n = 0; n < 12; n++) begin
            a8 = 8'($urandom_range(18));
            d8 = 8'($urandom_range(255));
            // Tuning bits only take the two legal codes
            if (a8 == 8'h00) begin
                d8[6:0] = d8[0] ? 7'h3C : 7'h28;
            end
            wr(a8, d8);
            rd_chk(8'h0C);
        end
        wrap_up();
    end
endmodule : sdadc_ctrl_tb
